// [hw/i2c_slave_interface.sv]
// Purpose: Byte-oriented I2C slave with clock stretching behind an APB register port.
// Assumes: pclk is far faster than SCL; SCL and SDA are open-drain pins.
// Notes: No time-out counter and no debounce; the interrupt is a one-cycle pulse.
`timescale 1ns/1ps
module i2c_slave_interface
    import i2c_slave_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic irq,
    output logic wake
);
    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_ADDR = 8'h02,
        ST_AACK = 8'h04,
        ST_HOLD = 8'h08,
        ST_RX = 8'h10,
        ST_RACK = 8'h20,
        ST_TX = 8'h40,
        ST_TACK = 8'h80
    } state_type;

    // ----------------------------------------
    // Pin synchronisers and bus events
    // ----------------------------------------
    logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {scl_m, scl_s, scl_d} <= 3'h7;
            {sda_m, sda_s, sda_d} <= 3'h7;
        end
        else
        begin
            {scl_m, scl_s, scl_d} <= {scl_i, scl_m, scl_s};
            {sda_m, sda_s, sda_d} <= {sda_i, sda_m, sda_s};
        end
    end

    wire start_det = scl_s && scl_d && sda_d && !sda_s;
    wire stop_det = scl_s && scl_d && !sda_d && sda_s;
    wire scl_rise = scl_s && !scl_d;
    wire scl_fall = !scl_s && scl_d;

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    logic [7:0] ctrl_r, addr_r, data_r;
    logic dir_r, ackc_r, wake_en_r;
    logic done_r, match_r, busy_r, rw_r, mack_r;
    logic [31:0] rdata_r;
    state_type st_r;
    logic [7:0] sh_r;
    logic [2:0] cnt_r;
    logic sda_drv_r, irq_r, wake_r;

    wire setup = psel && !penable;
    wire access = psel && penable;
    wire [7:0] off = paddr[7:0];
    wire mapped = (paddr[31:8] == 24'h000000) &&
                  (off == OFF_CTRL || off == OFF_STAT || off == OFF_ADDR || off == OFF_DATA);
    wire wr_ctrl = access && pwrite && mapped && off == OFF_CTRL;
    wire wr_stat = access && pwrite && mapped && off == OFF_STAT;
    wire wr_addr = access && pwrite && mapped && off == OFF_ADDR;
    wire wr_data = access && pwrite && mapped && off == OFF_DATA;
    wire rd_data = access && !pwrite && mapped && off == OFF_DATA;
    wire active = ctrl_r[EN_BIT] && ctrl_r[MODE_HI:MODE_LO] == MODE_I2C_SLAVE;
    wire [7:0] stat_v = {done_r, match_r, busy_r, dir_r, ackc_r, rw_r, wake_en_r, mack_r};
    wire [7:0] rd_v = off == OFF_CTRL ? ctrl_r : off == OFF_STAT ? stat_v :
                      off == OFF_ADDR ? addr_r : off == OFF_DATA ? data_r : 8'h00;
    // Releasing the stretch needs the access that matches the chosen direction.
    wire svc = (st_r == ST_HOLD) && (dir_r ? wr_data : rd_data);
    wire [7:0] byte_in = {sh_r[6:0], sda_s};
    wire addr_hit = sh_r[6:0] == addr_r[7:1];
    wire addr_end = (st_r == ST_ADDR) && scl_rise && cnt_r == LAST_BIT;

    assign pready = 1'b1;
    assign pslverr = access && !mapped;
    assign prdata = rdata_r;
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe = (st_r == ST_HOLD);
    assign sda_oe = sda_drv_r;
    assign irq = irq_r;
    assign wake = wake_r;

    // ----------------------------------------
    // Software registers
    // ----------------------------------------
    // Read data is captured in the setup cycle so the answer comes with zero wait states.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r <= CTRL_RST;
            addr_r <= ADDR_RST;
            rdata_r <= 32'h00000000;
            {dir_r, ackc_r, wake_en_r} <= 3'h0;
        end
        else
        begin
            rdata_r <= setup ? {24'h000000, rd_v} : rdata_r;
            if (wr_ctrl)
                ctrl_r <= pwdata[7:0] & CTRL_WMASK;
            if (wr_addr)
                addr_r <= pwdata[7:0];
            // Direction and ack control survive disable, so enable rise leaves them alone.
            if (wr_stat)
            begin
                dir_r <= pwdata[DIR_BIT];
                ackc_r <= pwdata[ACKC_BIT];
                wake_en_r <= pwdata[WAKE_BIT];
            end
        end
    end

    // ----------------------------------------
    // Bus engine
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r <= ST_IDLE;
            sh_r <= 8'h00;
            cnt_r <= 3'h0;
            sda_drv_r <= 1'b0;
            {done_r, match_r, busy_r, rw_r, mack_r} <= FLAG_RST;
            {irq_r, wake_r} <= 2'h0;
            data_r <= DATA_RST;
        end
        else
        begin
            irq_r <= 1'b0;
            wake_r <= 1'b0;
            if (wr_data)
                data_r <= pwdata[7:0];
            if (!active)
            begin
                // Disabled: flags sit at defaults, so the enable rise sees them fresh.
                st_r <= ST_IDLE;
                sda_drv_r <= 1'b0;
                {done_r, match_r, busy_r, rw_r, mack_r} <= FLAG_RST;
            end
            else if (start_det)
            begin
                busy_r <= 1'b1;
                st_r <= ST_ADDR;
                cnt_r <= 3'h0;
                done_r <= 1'b0;
                match_r <= 1'b0;
                sda_drv_r <= 1'b0;
            end
            else if (stop_det)
            begin
                busy_r <= 1'b0;
                st_r <= ST_IDLE;
                sda_drv_r <= 1'b0;
            end
            else
            begin
                unique case (st_r)
                    ST_IDLE:
                    begin
                    end
                    ST_ADDR:
                    begin
                        if (scl_rise)
                        begin
                            sh_r <= byte_in;
                            cnt_r <= cnt_r + 3'h1;
                            if (addr_end && addr_hit)
                            begin
                                match_r <= 1'b1;
                                rw_r <= sda_s;
                                done_r <= 1'b1;
                                irq_r <= 1'b1;
                                wake_r <= wake_en_r;
                            end
                            else if (addr_end)
                                st_r <= ST_IDLE;
                        end
                        else if (scl_fall && match_r)
                        begin
                            st_r <= ST_AACK;
                            sda_drv_r <= 1'b1;
                        end
                    end
                    ST_AACK, ST_RACK:
                    begin
                        if (scl_fall)
                        begin
                            sda_drv_r <= 1'b0;
                            st_r <= ST_HOLD;
                        end
                    end
                    ST_HOLD:
                    begin
                        if (svc)
                        begin
                            match_r <= 1'b0;
                            done_r <= 1'b0;
                            cnt_r <= 3'h0;
                            st_r <= dir_r ? ST_TX : ST_RX;
                            sh_r <= pwdata[7:0];
                            sda_drv_r <= dir_r && !pwdata[7];
                        end
                    end
                    ST_RX:
                    begin
                        if (scl_rise)
                        begin
                            sh_r <= byte_in;
                            cnt_r <= cnt_r + 3'h1;
                            if (cnt_r == LAST_BIT)
                            begin
                                data_r <= byte_in;
                                done_r <= 1'b1;
                                irq_r <= 1'b1;
                            end
                        end
                        else if (scl_fall && done_r)
                        begin
                            st_r <= ST_RACK;
                            sda_drv_r <= !ackc_r;
                        end
                    end
                    ST_TX:
                    begin
                        if (scl_fall)
                        begin
                            if (cnt_r == LAST_BIT)
                            begin
                                st_r <= ST_TACK;
                                sda_drv_r <= 1'b0;
                            end
                            else
                            begin
                                sh_r <= {sh_r[6:0], 1'b0};
                                sda_drv_r <= !sh_r[6];
                                cnt_r <= cnt_r + 3'h1;
                            end
                        end
                    end
                    ST_TACK:
                    begin
                        if (scl_rise)
                        begin
                            mack_r <= sda_s;
                            done_r <= 1'b1;
                            irq_r <= 1'b1;
                        end
                        else if (scl_fall)
                            st_r <= mack_r ? ST_IDLE : ST_HOLD;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_busy_start: assert property (active && start_det |=> busy_r)
        else $error("busy not set after START");
    a_busy_stop: assert property (active && stop_det && !start_det |=> !busy_r)
        else $error("busy not cleared after STOP");
    a_tx_done_low: assert property (st_r == ST_TX |-> !done_r)
        else $error("done flag high while transmitting");
    a_match_set: assert property (active && !start_det && !stop_det && addr_end && addr_hit
        |=> match_r && irq_r && rw_r == $past(sda_s))
        else $error("match, interrupt or rw not captured");
    a_mismatch_idle: assert property (active && !start_det && !stop_det && addr_end && !addr_hit
        |=> st_r == ST_IDLE && !match_r)
        else $error("mismatch did not idle");
    a_addr_ack: assert property (st_r == ST_AACK |-> sda_oe)
        else $error("address ack not driven");
    a_rx_ack: assert property (st_r == ST_RACK |-> sda_oe == !ackc_r)
        else $error("data ack level wrong");
    a_rx_load: assert property (active && !start_det && !stop_det && st_r == ST_RX && scl_rise
        && cnt_r == LAST_BIT |=> data_r == $past(byte_in) && done_r)
        else $error("received byte not loaded");
    a_nack_release: assert property (active && !start_det && !stop_det && st_r == ST_TACK
        && scl_fall && mack_r |=> st_r == ST_IDLE && !sda_oe)
        else $error("transmitter kept SDA after nack");
    a_hold_scl: assert property (st_r == ST_HOLD && !svc && active && !start_det && !stop_det
        |=> scl_oe)
        else $error("SCL stretch lost");
    a_disable_flags: assert property (!active |=> stat_v[7:5] == 3'h4 && !rw_r && mack_r)
        else $error("flags not at default when disabled");

    c_match: cover property (addr_end && addr_hit);
    c_rx_byte: cover property (st_r == ST_RACK && sda_oe);
    c_tx_nack: cover property (st_r == ST_TACK && scl_fall && mack_r);
    c_stop: cover property (busy_r && stop_det);
endmodule

// [hw/i2c_slave_pkg.sv]
// Purpose: Shared constants for the I2C slave engine.
// Assumes: APB register map with one aligned 32-bit word per register.
// Notes: Only the low byte of each word is used; upper bits read as zero.
package i2c_slave_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STAT = 8'h04;
    localparam logic [7:0] OFF_ADDR = 8'h08;
    localparam logic [7:0] OFF_DATA = 8'h0C;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int MODE_HI = 7;
    localparam int MODE_LO = 5;
    localparam int EN_BIT = 1;
    localparam int DONE_BIT = 7;
    localparam int MATCH_BIT = 6;
    localparam int BUSY_BIT = 5;
    localparam int DIR_BIT = 4;
    localparam int ACKC_BIT = 3;
    localparam int RW_BIT = 2;
    localparam int WAKE_BIT = 1;
    localparam int MACK_BIT = 0;
    // ----------------------------------------
    // Values and reset values
    // ----------------------------------------
    localparam logic [2:0] MODE_I2C_SLAVE = 3'h6;
    localparam logic [7:0] CTRL_RST = 8'hE0;
    localparam logic [7:0] CTRL_WMASK = 8'hEE;
    localparam logic [7:0] ADDR_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [4:0] FLAG_RST = 5'h11;
    localparam logic [7:0] STAT_RST = 8'h81;
    localparam logic [2:0] LAST_BIT = 3'h7;
endpackage

// [tb/i2c_master_model.sv]
// Purpose: Behavioural I2C bus master that drives the slave under test.
// Assumes: Both lines are open drain with pull-ups; the bench resolves the wires.
// Notes: A stretched SCL is waited on for at most 20 us, after which hung is raised.
`timescale 1ns/1ps
module i2c_master_model (
    input wire logic scl_line,
    input wire logic sda_line,
    output logic scl_pull,
    output logic sda_pull,
    output logic hung
);
    initial
    begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
        hung = 1'b0;
    end
    // ----------------------------------------
    // Bus phases
    // ----------------------------------------
    // Releasing SCL is not enough: the slave may stretch, so the high phase starts when the wire is high.
    task automatic rise();
        int n;
        scl_pull = 1'b0;
        n = 0;
        while (scl_line !== 1'b1 && n < 20000)
        begin
            #1 n++;
        end
        if (n >= 20000)
            hung = 1'b1;
        #32;
    endtask
    task automatic clk_bit(input logic b, output logic s);
        #8 sda_pull = !b;
        #24 rise();
        s = sda_line;
        scl_pull = 1'b1;
    endtask
    task automatic start();
        #32 sda_pull = 1'b1;
        #32 scl_pull = 1'b1;
    endtask
    task automatic stop();
        #8 sda_pull = 1'b1;
        #24 rise();
        sda_pull = 1'b0;
        #32;
    endtask
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            clk_bit(d[i], s);
        clk_bit(1'b1, ack);
    endtask
    task automatic read_byte(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
            clk_bit(1'b1, d[i]);
        clk_bit(ack, s);
    endtask
endmodule

// [tb/i2c_slave_interface_tb.sv]
// Purpose: Self-checking bench for the I2C slave behind its APB port.
// Assumes: Zero-wait APB slave; SCL and SDA pulled up; scl_o and sda_o drive low.
// Notes: Expected bytes travel in a queue; interrupt and wake pulses are counted.
`timescale 1ns/1ps
module i2c_slave_interface_tb;
    import i2c_slave_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata, r;
    logic scl_o, scl_oe, sda_o, sda_oe, irq, wake, m_scl, m_sda, hung, err, ack;
    logic [7:0] own, rd;
    logic [7:0] exp_q[$];
    wire scl_line = (scl_oe ? scl_o : 1'b1) & !m_scl;
    wire sda_line = (sda_oe ? sda_o : 1'b1) & !m_sda;
    int n_fail = 0;
    int check_count = 0;
    int irq_n = 0;
    int wake_n = 0;
    int seed = 84829;
    i2c_slave_interface dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl_line),
        .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq), .wake(wake));
    i2c_master_model m (.scl_line(scl_line), .sda_line(sda_line), .scl_pull(m_scl), .sda_pull(m_sda),
        .hung(hung));
    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = !pclk;
    end
    always @(posedge pclk)
    begin
        if (irq === 1'b1)
            irq_n++;
        if (wake === 1'b1)
            wake_n++;
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic close_out();
        $display("Counts: checks=%0d mismatches=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {24'h000000, a};
        pwdata <= {24'($random(seed)), d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            n_fail++;
            close_out();
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] msk, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(r & {24'h000000, msk}, {24'h000000, e});
    endtask
    initial
    begin
        #200000;
        n_fail++;
        close_out();
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        {psel, penable, pwrite, presetn} = 4'h0;
        paddr = 32'h00000000;
        pwdata = 32'h00000000;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        rdchk(OFF_CTRL, 8'hFF, CTRL_RST);
        rdchk(OFF_STAT, 8'hFF, STAT_RST);
        rdchk(OFF_ADDR, 8'hFF, ADDR_RST);
        rdchk(OFF_DATA, 8'hFF, DATA_RST);
        apb(1'b0, 8'h10, 8'h00);
        chk(err, 1);
        chk(r, 32'h00000000);
        apb(1'b1, OFF_STAT, 8'hFF);
        rdchk(OFF_STAT, 8'hFF, 8'h9B);
        apb(1'b1, OFF_CTRL, 8'hDF);
        rdchk(OFF_CTRL, 8'hFF, 8'hCE);
        rdchk(OFF_STAT, 8'hFF, 8'h9B);
        own = 8'($random(seed));
        apb(1'b1, OFF_ADDR, own);
        rdchk(OFF_ADDR, 8'hFF, own);
        $display("Test registers done");
        apb(1'b1, OFF_STAT, 8'h00);
        m.start();
        repeat (8) @(posedge pclk);
        rdchk(OFF_STAT, 8'h20, 8'h20);
        m.write_byte({own[7:1] ^ 7'h40, 1'b0}, ack);
        chk(ack, 1);
        rdchk(OFF_STAT, 8'h60, 8'h20);
        m.stop();
        repeat (8) @(posedge pclk);
        rdchk(OFF_STAT, 8'h20, 8'h00);
        chk(irq_n, 0);
        $display("Test address mismatch done");
        m.start();
        m.write_byte({own[7:1], 1'b0}, ack);
        chk(ack, 0);
        rdchk(OFF_STAT, 8'hE4, 8'hE0);
        // The stretch starts a few clocks after the ninth SCL fall, behind the pin synchroniser.
        repeat (4) @(posedge pclk);
        chk(scl_oe, 1);
        chk(irq_n, 1);
        apb(1'b1, OFF_STAT, 8'h00);
        apb(1'b0, OFF_DATA, 8'h00);
        repeat (2) @(posedge pclk);
        chk(scl_oe, 0);
        for (int i = 0; i < 2; i++)
        begin
            apb(1'b1, OFF_STAT, {4'h0, i[0], 3'h0});
            exp_q.push_back(8'($random(seed)));
            m.write_byte(exp_q[$], ack);
            chk(ack, i);
            repeat (4) @(posedge pclk);
            chk(scl_oe, 1);
            rdchk(OFF_STAT, 8'hE0, 8'hA0);
            rdchk(OFF_DATA, 8'hFF, exp_q.pop_front());
        end
        m.stop();
        chk(irq_n, 3);
        chk(wake_n, 0);
        $display("Test master write done");
        apb(1'b1, OFF_STAT, 8'h02);
        m.start();
        m.write_byte({own[7:1], 1'b1}, ack);
        chk(ack, 0);
        rdchk(OFF_STAT, 8'hE6, 8'hE6);
        chk(wake_n, 1);
        for (int i = 0; i < 2; i++)
        begin
            exp_q.push_back(8'($random(seed)));
            apb(1'b1, OFF_STAT, 8'h10);
            apb(1'b1, OFF_DATA, exp_q[$]);
            m.read_byte(i[0], rd);
            chk(rd, exp_q.pop_front());
            rdchk(OFF_STAT, 8'h81, {1'b1, 6'h00, i[0]});
        end
        repeat (8) @(posedge pclk);
        chk({scl_oe, sda_oe}, 0);
        m.stop();
        repeat (8) @(posedge pclk);
        rdchk(OFF_STAT, 8'h20, 8'h00);
        chk(irq_n, 6);
        chk(wake_n, 1);
        chk(hung, 0);
        $display("Test master read done");
        close_out();
    end
endmodule
